// file: lbd_dimming_ctrl.sv
// Top of the backlight dimming control: I2C register slave, fault flags, duty filter, PWM
//
// Functional notes
// - Clear bit clears latches, masks over-voltage
// - Bit 5 reports string short fault
// - Bit 4 reports string open fault
// - Bit 3 reports sync signal present
// - Bit 2 reports over-temperature fault
// - Bit 1 reports over-voltage fault
// - Bit 0 is OR of faults
// - Input duty replaced after two out-of-window samples
// - Fast bit picks 9 or 10-bit rate
// - Open/short checked only when enabled
// - Sync enable lets lock loop track
// - Stagger phases per string, internal mode only
// - Duty source: measured or register, internal only
// - Internal bit selects oscillator, enables loop
// - Analog level code drives current DAC
// - Duty is 10 bits over two registers
// - Lock loop divider is 18 bits
// - Write: address, index, one data byte
// - Read returns previously indexed register
`timescale 1ns/1ps
`include "lbd_consts.svh"
module lbd_dimming_ctrl #(
    parameter int STRINGS      = 8,
    parameter int OVP_MASK_CYC = `LBD_OVP_MASK_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_oe_o,
    input  wire logic               duty_input_pin_i,
    input  wire logic               sync_i,
    input  wire logic               short_det_i,
    input  wire logic               open_det_i,
    input  wire logic               otemp_det_i,
    input  wire logic               ovolt_det_i,
    output logic [STRINGS-1:0]      string_pwm_o,
    output logic [4:0]              analog_level_code_o,
    output logic                    lock_loop_enable_o,
    output logic                    lock_loop_track_o,
    output logic [17:0]             lock_loop_divider_o
);
    import lbd_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] raw_s;
    logic       scl_s, sda_s, duty_input_pin_s, sync_s, shrt_s, open_s, otmp_s, ovlt_s;

    lbd_sync2 #(.WIDTH(8)) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  ({scl_i, sda_i, duty_input_pin_i, sync_i,
                    short_det_i, open_det_i, otemp_det_i, ovolt_det_i}),
        .sync_o   (raw_s)
    );
    assign {scl_s, sda_s, duty_input_pin_s, sync_s, shrt_s, open_s, otmp_s, ovlt_s} = raw_s;

    // ----------------------------------------------------------------
    // Registers and I2C slave
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_r, ctrl_nxt, lvl_r, lvl_nxt, dhi_r, dhi_nxt, dlo_r, dlo_nxt;
    logic [7:0]  rate_r, rate_nxt, ptop_r, ptop_nxt, pmid_r, pmid_nxt, pbot_r, pbot_nxt;
    logic [7:0]  idx_r, idx_nxt, sh_r, sh_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic        scl_d_r, sda_d_r, rd_r, rd_nxt, first_r, first_nxt, oe_nxt;
    logic        clr_nxt, clr_r;
    lbd_i2c_state_type st_r, st_nxt;
    logic [7:0]  flt_rd;
    logic        start_c, stop_c, rise_c, fall_c;

    function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [7:0] f,
                                          input logic [7:0] c, input logic [7:0] l,
                                          input logic [7:0] h, input logic [7:0] o,
                                          input logic [7:0] r, input logic [7:0] t,
                                          input logic [7:0] m, input logic [7:0] b);
        if (a == `LBD_REG_FAULT)        rd_reg = f;
        else if (a == `LBD_REG_CTRL)    rd_reg = c;
        else if (a == `LBD_REG_LEVEL)   rd_reg = {3'h0, l[4:0]};
        else if (a == `LBD_REG_DUTY_HI) rd_reg = {6'h00, h[1:0]};
        else if (a == `LBD_REG_DUTY_LO) rd_reg = o;
        else if (a == `LBD_REG_RATE)    rd_reg = r;
        else if (a == `LBD_REG_PLL_TOP) rd_reg = {6'h00, t[1:0]};
        else if (a == `LBD_REG_PLL_MID) rd_reg = m;
        else if (a == `LBD_REG_PLL_BOT) rd_reg = b;
        else                            rd_reg = 8'h00;
    endfunction : rd_reg

    assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_c  = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign rise_c  = scl_s && !scl_d_r;
    assign fall_c  = !scl_s && scl_d_r;

    always_comb begin
        st_nxt = st_r; bit_nxt = bit_r; sh_nxt = sh_r; idx_nxt = idx_r;
        rd_nxt = rd_r; first_nxt = first_r; oe_nxt = sda_oe_o; clr_nxt = 1'b0;
        ctrl_nxt = ctrl_r; lvl_nxt = lvl_r; dhi_nxt = dhi_r; dlo_nxt = dlo_r;
        rate_nxt = rate_r; ptop_nxt = ptop_r; pmid_nxt = pmid_r; pbot_nxt = pbot_r;
        if (start_c) begin
            st_nxt = LBD_ADDR; bit_nxt = 4'h0; oe_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = LBD_IDLE; oe_nxt = 1'b0;
        end else begin
            case (st_r)
                LBD_ADDR: begin
                    if (rise_c) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end else if (fall_c && bit_r == 4'h8) begin
                        if (sh_r[7:1] == `LBD_I2C_ADDR) begin
                            oe_nxt = 1'b1; rd_nxt = sh_r[0]; first_nxt = 1'b1;
                            st_nxt = LBD_AACK;
                        end else begin
                            st_nxt = LBD_IDLE;
                        end
                    end
                end
                LBD_AACK, LBD_RACK: begin
                    if (fall_c) begin
                        bit_nxt = 4'h0;
                        if (rd_r) begin
                            // Register read from the stored index, no increment
                            sh_nxt = rd_reg(idx_r, flt_rd, ctrl_r, lvl_r, dhi_r, dlo_r,
                                            rate_r, ptop_r, pmid_r, pbot_r);
                            oe_nxt = !sh_nxt[7];
                            st_nxt = LBD_TXB;
                        end else begin
                            oe_nxt = 1'b0; st_nxt = LBD_RXB;
                        end
                    end
                end
                LBD_RXB: begin
                    if (rise_c) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end else if (fall_c && bit_r == 4'h8) begin
                        oe_nxt = 1'b1; st_nxt = LBD_RACK; first_nxt = 1'b0;
                        if (first_r) begin
                            idx_nxt = sh_r;
                        end else if (idx_r == `LBD_REG_FAULT) begin
                            clr_nxt = sh_r[`LBD_FLT_CLEAR];
                        end else if (idx_r == `LBD_REG_CTRL)    ctrl_nxt = sh_r;
                        else if (idx_r == `LBD_REG_LEVEL)   lvl_nxt = sh_r;
                        else if (idx_r == `LBD_REG_DUTY_HI) dhi_nxt = sh_r;
                        else if (idx_r == `LBD_REG_DUTY_LO) dlo_nxt = sh_r;
                        else if (idx_r == `LBD_REG_RATE)    rate_nxt = sh_r;
                        else if (idx_r == `LBD_REG_PLL_TOP) ptop_nxt = sh_r;
                        else if (idx_r == `LBD_REG_PLL_MID) pmid_nxt = sh_r;
                        else if (idx_r == `LBD_REG_PLL_BOT) pbot_nxt = sh_r;
                    end
                end
                LBD_TXB: begin
                    if (fall_c) begin
                        bit_nxt = bit_r + 4'h1;
                        sh_nxt = {sh_r[6:0], 1'b0};
                        if (bit_r == 4'h7) begin
                            oe_nxt = 1'b0; st_nxt = LBD_TACK;
                        end else begin
                            oe_nxt = !sh_r[6];
                        end
                    end
                end
                LBD_TACK: begin
                    // A master NACK ends the read; wait for stop
                    if (rise_c) st_nxt = sda_s ? LBD_IDLE : LBD_RACK;
                end
                default: st_nxt = LBD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= LBD_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; idx_r <= 8'h00;
            rd_r <= 1'b0; first_r <= 1'b0; sda_oe_o <= 1'b0; clr_r <= 1'b0;
            scl_d_r <= 1'b1; sda_d_r <= 1'b1;
            ctrl_r <= `LBD_RST_CTRL; lvl_r <= `LBD_RST_LEVEL;
            dhi_r <= `LBD_RST_DUTY_HI; dlo_r <= `LBD_RST_DUTY_LO; rate_r <= `LBD_RST_RATE;
            ptop_r <= `LBD_RST_PLL_TOP; pmid_r <= `LBD_RST_PLL_MID; pbot_r <= `LBD_RST_PLL_BOT;
        end else begin
            st_r <= st_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; idx_r <= idx_nxt;
            rd_r <= rd_nxt; first_r <= first_nxt; sda_oe_o <= oe_nxt; clr_r <= clr_nxt;
            scl_d_r <= scl_s; sda_d_r <= sda_s;
            ctrl_r <= ctrl_nxt; lvl_r <= lvl_nxt; dhi_r <= dhi_nxt; dlo_r <= dlo_nxt;
            rate_r <= rate_nxt; ptop_r <= ptop_nxt; pmid_r <= pmid_nxt; pbot_r <= pbot_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Fault flags
    // ----------------------------------------------------------------
    logic        shrt_r, shrt_nxt, open_r, open_nxt, otmp_r, otmp_nxt, ovlt_r, ovlt_nxt;
    logic [15:0] mask_r, mask_nxt;
    logic        syn_r, syn_nxt;
    logic [15:0] syn_age_r, syn_age_nxt;
    logic        sync_d_r;

    always_comb begin
        // Detection wins over a clear in the same cycle, except over-voltage, which the clear hides
        shrt_nxt = (shrt_r && !clr_r) || (shrt_s && ctrl_r[`LBD_CTL_STRING_FAULT_CHECK_ENABLE]);
        open_nxt = (open_r && !clr_r) || (open_s && ctrl_r[`LBD_CTL_STRING_FAULT_CHECK_ENABLE]);
        otmp_nxt = (otmp_r && !clr_r) || otmp_s;
        mask_nxt = clr_r ? 16'(OVP_MASK_CYC) : (mask_r != 16'h0000 ? mask_r - 16'h0001 : mask_r);
        ovlt_nxt = ovlt_s && (mask_r == 16'h0000) && !clr_r;
        // Sync counts as present while edges keep arriving within 64K cycles
        syn_age_nxt = (sync_s != sync_d_r) ? 16'h0000 :
                      (syn_age_r != 16'hFFFF ? syn_age_r + 16'h0001 : syn_age_r);
        syn_nxt = (syn_age_nxt != 16'hFFFF) && (sync_s != sync_d_r || syn_r);
        flt_rd = {2'b00, shrt_r, open_r, syn_r, otmp_r, ovlt_r,
                  shrt_r | open_r | otmp_r | ovlt_r};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shrt_r <= 1'b0; open_r <= 1'b0; otmp_r <= 1'b0; ovlt_r <= 1'b0;
            mask_r <= 16'h0000; syn_r <= 1'b0; syn_age_r <= 16'hFFFF; sync_d_r <= 1'b0;
        end else begin
            shrt_r <= shrt_nxt; open_r <= open_nxt; otmp_r <= otmp_nxt; ovlt_r <= ovlt_nxt;
            mask_r <= mask_nxt; syn_r <= syn_nxt; syn_age_r <= syn_age_nxt; sync_d_r <= sync_s;
        end
    end

    // ----------------------------------------------------------------
    // Duty measurement and deviation window
    // ----------------------------------------------------------------
    logic [3:0]  tdiv_r, tdiv_nxt;
    logic        tick;
    logic [9:0]  hi_r, hi_nxt, per_r, per_nxt, saved_r, saved_nxt;
    logic        pin_d_r, miss_r, miss_nxt;
    logic [9:0]  meas, dev, win, duty_sel;

    assign tick = (tdiv_r == 4'(`LBD_SYS_DIV - 1));

    always_comb begin
        tdiv_nxt = tick ? 4'h0 : tdiv_r + 4'h1;
        hi_nxt = hi_r; per_nxt = per_r; saved_nxt = saved_r; miss_nxt = miss_r;
        // Coarse 10-bit duty: high time over period, saturated
        meas = (per_r == 10'h000) ? 10'h000 :
               10'(({10'h000, hi_r} * 20'd1023) / {10'h000, per_r});
        dev  = (meas > saved_r) ? meas - saved_r : saved_r - meas;
        win  = {8'h00, ctrl_r[`LBD_CTL_WIN_HI:`LBD_CTL_WIN_LO]};
        if (duty_input_pin_s && !pin_d_r) begin
            if (dev > win) begin
                if (miss_r) saved_nxt = meas;
                miss_nxt = !miss_r;
            end else begin
                miss_nxt = 1'b0;
            end
            hi_nxt = 10'h000; per_nxt = 10'h000;
        end else if (tick) begin
            if (per_r != 10'h3FF) per_nxt = per_r + 10'h001;
            if (duty_input_pin_s && hi_r != 10'h3FF) hi_nxt = hi_r + 10'h001;
        end
        duty_sel = ctrl_r[`LBD_CTL_INT_DUTY] ? {dhi_r[1:0], dlo_r} : saved_r;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdiv_r <= 4'h0; hi_r <= 10'h000; per_r <= 10'h000; saved_r <= 10'h000;
            pin_d_r <= 1'b0; miss_r <= 1'b0;
        end else begin
            tdiv_r <= tdiv_nxt; hi_r <= hi_nxt; per_r <= per_nxt; saved_r <= saved_nxt;
            pin_d_r <= duty_input_pin_s; miss_r <= miss_nxt;
        end
    end

    // ----------------------------------------------------------------
    // PWM generation and outputs
    // ----------------------------------------------------------------
    logic [STRINGS-1:0] int_pwm;

    lbd_pwm #(.STRINGS(STRINGS)) u_pwm (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .tick_i    (tick),
        .fast_i    (ctrl_r[`LBD_CTL_FAST]),
        .stagger_i (ctrl_r[`LBD_CTL_STAGGER]),
        .rate_i    (rate_r),
        .duty_i    (duty_sel),
        .pwm_o     (int_pwm)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            string_pwm_o        <= '0;
            analog_level_code_o <= 5'h00;
            lock_loop_enable_o  <= 1'b0;
            lock_loop_track_o   <= 1'b0;
            lock_loop_divider_o <= 18'h00000;
        end else begin
            string_pwm_o <= ctrl_r[`LBD_CTL_INT_PWM] ? int_pwm : {STRINGS{duty_input_pin_s}};
            analog_level_code_o <= lvl_r[4:0];
            lock_loop_enable_o  <= ctrl_r[`LBD_CTL_INT_PWM];
            lock_loop_track_o   <= ctrl_r[`LBD_CTL_INT_PWM] && ctrl_r[`LBD_CTL_SYNC_EN];
            lock_loop_divider_o <= {ptop_r[1:0], pmid_r, pbot_r};
        end
    end
endmodule : lbd_dimming_ctrl

// file: lbd_consts.svh
// Register offsets, field positions, reset values and timing counts of the dimming control block
`ifndef LBD_CONSTS_SVH
`define LBD_CONSTS_SVH

`define LBD_REG_FAULT          8'h00
`define LBD_REG_CTRL           8'h01
`define LBD_REG_LEVEL          8'h02
`define LBD_REG_DUTY_HI        8'h03
`define LBD_REG_DUTY_LO        8'h04
`define LBD_REG_RATE           8'h05
`define LBD_REG_PLL_TOP        8'h06
`define LBD_REG_PLL_MID        8'h07
`define LBD_REG_PLL_BOT        8'h08

`define LBD_FLT_CLEAR          7
`define LBD_FLT_SHORT          5
`define LBD_FLT_OPEN           4
`define LBD_FLT_SYNC           3
`define LBD_FLT_OTEMP          2
`define LBD_FLT_OVOLT          1
`define LBD_FLT_ANY            0

`define LBD_CTL_WIN_HI         7
`define LBD_CTL_WIN_LO         6
`define LBD_CTL_FAST           5
`define LBD_CTL_STRING_FAULT_CHECK_ENABLE         4
`define LBD_CTL_SYNC_EN        3
`define LBD_CTL_STAGGER        2
`define LBD_CTL_INT_DUTY       1
`define LBD_CTL_INT_PWM        0

`define LBD_RST_CTRL           8'hB5
`define LBD_RST_LEVEL          8'h1F
`define LBD_RST_DUTY_HI        8'h00
`define LBD_RST_DUTY_LO        8'h00
`define LBD_RST_RATE           8'h00
`define LBD_RST_PLL_TOP        8'h00
`define LBD_RST_PLL_MID        8'h00
`define LBD_RST_PLL_BOT        8'h08

`define LBD_I2C_ADDR           7'h2F

`define LBD_CLK_MHZ            125
`define LBD_SYS_MHZ            10
`define LBD_OVP_MASK_US        32
`define LBD_OVP_MASK_CYC       (`LBD_OVP_MASK_US * `LBD_CLK_MHZ)
`define LBD_SYS_DIV            ((`LBD_CLK_MHZ + `LBD_SYS_MHZ - 1) / `LBD_SYS_MHZ)

`endif

// file: lbd_pkg.sv
// Types shared by the dimming control block
package lbd_pkg;
    typedef enum logic [2:0] {
        LBD_IDLE  = 3'b000,
        LBD_ADDR  = 3'b001,
        LBD_AACK  = 3'b011,
        LBD_RXB   = 3'b010,
        LBD_RACK  = 3'b110,
        LBD_TXB   = 3'b111,
        LBD_TACK  = 3'b101
    } lbd_i2c_state_type;
endpackage : lbd_pkg

// file: lbd_sync2.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module lbd_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : lbd_sync2

// file: lbd_pwm.sv
// Internal PWM counter with 9/10-bit resolution, rate divider and stagger per string
`timescale 1ns/1ps
`include "lbd_consts.svh"
module lbd_pwm #(
    parameter int STRINGS = 8
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               tick_i,
    input  wire logic               fast_i,
    input  wire logic               stagger_i,
    input  wire logic [7:0]         rate_i,
    input  wire logic [9:0]         duty_i,
    output logic      [STRINGS-1:0] pwm_o
);
    import lbd_pkg::*;
    logic [7:0]         pre_r, pre_nxt;
    logic [9:0]         cnt_r, cnt_nxt;
    logic [STRINGS-1:0] pwm_nxt;
    logic [9:0]         top;
    logic [9:0]         ph;
    logic [9:0]         lvl;

    always_comb begin
        top     = fast_i ? 10'h1FF : 10'h3FF;
        lvl     = fast_i ? {1'b0, duty_i[9:1]} : duty_i;
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        pwm_nxt = pwm_o;
        if (tick_i) begin
            // Period is (2^bits) x (rate + 1) system ticks
            if (pre_r >= rate_i) begin
                pre_nxt = 8'h00;
                cnt_nxt = (cnt_r >= top) ? 10'h000 : cnt_r + 10'h001;
            end else begin
                pre_nxt = pre_r + 8'h01;
            end
        end
        for (int s = 0; s < STRINGS; s++) begin
            // With stagger_i set, each string offset from the one before by one STRINGS-th of the period (one eighth for 8 strings)
            ph = stagger_i ? ((cnt_r + 10'((s * (int'(top) + 1)) / STRINGS)) & top) : cnt_r;
            pwm_nxt[s] = (duty_i == 10'h3FF) ? 1'b1 : (ph < lvl);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_r <= 8'h00;
            cnt_r <= 10'h000;
            pwm_o <= '0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            pwm_o <= pwm_nxt;
        end
    end
endmodule : lbd_pwm

// file: lbd_asserts.sv
// Port checker for the dimming control top
`timescale 1ns/1ps
module lbd_asserts #(
    parameter int STRINGS = 8
) (
    input wire logic               clk_i,
    input wire logic               arst_n_i,
    input wire logic               scl_i,
    input wire logic               sda_oe_o,
    input wire logic               duty_input_pin_i,
    input wire logic [STRINGS-1:0] string_pwm_o,
    input wire logic [4:0]         analog_level_code_o,
    input wire logic               lock_loop_enable_o,
    input wire logic               lock_loop_track_o,
    input wire logic [17:0]        lock_loop_divider_o
);
    logic [2:0] up_r;
    logic [2:0] up_nxt;
    logic       up_ok;
    // Outputs settle from reset values a few cycles after release
    always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) up_r <= 3'h0;
        else up_r <= up_nxt;
    end
    assign up_ok = (up_r == 3'h7);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_track; lock_loop_track_o |-> lock_loop_enable_o; endproperty
    a_track: assert property (p_track) else $error("track without enable");
    property p_div; up_ok && $changed(lock_loop_divider_o) |-> !scl_i; endproperty
    a_div: assert property (p_div) else $error("divider moved with SCL high");
    property p_lvl; up_ok && $changed(analog_level_code_o) |-> !scl_i; endproperty
    a_lvl: assert property (p_lvl) else $error("level moved with SCL high");
    property p_en; up_ok && $changed(lock_loop_enable_o) |-> !scl_i; endproperty
    a_en: assert property (p_en) else $error("enable moved with SCL high");
    property p_ack; up_ok && $changed(sda_oe_o) |-> !scl_i; endproperty
    a_ack: assert property (p_ack) else $error("SDA drive moved with SCL high");
    property p_hold; up_ok && sda_oe_o && $rose(scl_i) |-> sda_oe_o [*6]; endproperty
    a_hold: assert property (p_hold) else $error("SDA drive dropped in high phase");
    property p_idle; scl_i [*8] ##1 scl_i [*8] |-> !sda_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("SDA driven on idle bus");
    property p_dir;
        (up_ok && !lock_loop_enable_o && $stable(duty_input_pin_i)) [*8]
            |-> string_pwm_o == {STRINGS{duty_input_pin_i}};
    endproperty
    a_dir: assert property (p_dir) else $error("direct dimming off pin");
    c_ack: cover property ($rose(sda_oe_o));
    c_trk: cover property ($rose(lock_loop_track_o));
    c_dir: cover property ($fell(lock_loop_enable_o));
endmodule : lbd_asserts
bind lbd_dimming_ctrl lbd_asserts #(.STRINGS(STRINGS)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .scl_i(scl_i), .sda_oe_o(sda_oe_o), .duty_input_pin_i(duty_input_pin_i),
    .string_pwm_o(string_pwm_o), .analog_level_code_o(analog_level_code_o),
    .lock_loop_enable_o(lock_loop_enable_o), .lock_loop_track_o(lock_loop_track_o),
    .lock_loop_divider_o(lock_loop_divider_o));

// file: lbd_i2c_host.sv
// I2C host model that reaches the registers of the dimming control
`timescale 1ns/1ps
`include "lbd_consts.svh"
module lbd_i2c_host (
    input  wire logic clk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic low_r = 1'b0;
    // Pull-up bus: released by both sides reads high
    assign sda_o = !(low_r || sda_oe_i);
    initial scl_o = 1'b1;
    task automatic hw(input int n);
        repeat (n) @(negedge clk_i);
    endtask : hw
    task automatic go();
        low_r = 1'b0;
        hw(6);
        scl_o = 1'b1;
        hw(11);
        low_r = 1'b1;
        hw(11);
        scl_o = 1'b0;
    endtask : go
    task automatic stop();
        low_r = 1'b1;
        hw(6);
        scl_o = 1'b1;
        hw(11);
        low_r = 1'b0;
        hw(11);
    endtask : stop
    // Byte plus ack slot; SCL low and high 11 cycles each, above the slave's minimum
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            hw(5);
            low_r = !d[i];
            hw(6);
            scl_o = 1'b1;
            hw(6);
            q[i] = sda_o;
            hw(5);
            scl_o = 1'b0;
        end
    endtask : xb
    task automatic wr(input logic [6:0] a, input logic [7:0] x, input logic [7:0] d,
                      output logic nak);
        logic [8:0] q0, q1, q2;
        go();
        xb({a, 2'b01}, q0);
        xb({x, 1'b1}, q1);
        xb({d, 1'b1}, q2);
        stop();
        nak = q0[0] | q1[0] | q2[0];
    endtask : wr
    task automatic rd(input logic [7:0] x, output logic [7:0] d);
        logic [8:0] q;
        go();
        xb({`LBD_I2C_ADDR, 2'b01}, q);
        xb({x, 1'b1}, q);
        go();
        xb({`LBD_I2C_ADDR, 2'b11}, q);
        xb(9'h1FF, q);
        stop();
        d = q[8:1];
    endtask : rd
endmodule : lbd_i2c_host

// file: tb.sv
// Self-checking bench of the dimming control block
`timescale 1ns/1ps
`include "lbd_consts.svh"
module tb;
    localparam logic [7:0] RST_V [9] = '{8'h00, 8'hB5, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00,
                                        8'h00, 8'h08};
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        scl, sda, sda_oe, en, trk;
    logic        pin = 1'b0;
    logic        sync;
    logic        sync_run = 1'b0;
    logic [3:0]  flt = 4'h0;
    logic [7:0]  pwm;
    logic [4:0]  lvl;
    logic [17:0] div;
    logic [7:0]  q;
    logic        nak;
    int          bad_count = 0;
    int          num_checks = 0;
    always #4 clk_i = !clk_i;
    // Toggles on falling edges only; parked low while no sync run is wanted
    always #96 sync = sync_run ? !sync : 1'b0;
    lbd_i2c_host HOST (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    lbd_dimming_ctrl #(.OVP_MASK_CYC(2000)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .scl_i(scl), .sda_i(sda), .sda_oe_o(sda_oe), .duty_input_pin_i(pin), .sync_i(sync),
        .short_det_i(flt[3]), .open_det_i(flt[2]), .otemp_det_i(flt[1]), .ovolt_det_i(flt[0]),
        .string_pwm_o(pwm), .analog_level_code_o(lvl), .lock_loop_enable_o(en),
        .lock_loop_track_o(trk), .lock_loop_divider_o(div));
    task automatic chk(input logic [17:0] g, input logic [17:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, g, e);
        end
    endtask : chk
    task automatic rr(input logic [7:0] x, input logic [7:0] e);
        HOST.rd(x, q);
        chk({10'h0, q}, {10'h0, e}, "read");
    endtask : rr
    task automatic ww(input logic [7:0] x, input logic [7:0] d);
        HOST.wr(`LBD_I2C_ADDR, x, d, nak);
        chk({17'h0, nak}, 18'h0, "ack");
    endtask : ww
    task automatic pulse(input logic [3:0] f);
        flt = f;
        HOST.hw(10);
        flt = 4'h0;
    endtask : pulse
    // Rise-to-rise of string 0, skipping the first period after a change
    task automatic per(input logic [17:0] e);
        int t0, cnt;
        logic p;
        cnt = 0;
        t0 = 0;
        p = pwm[0];
        for (int k = 0; k < 50000 && cnt < 3; k++) begin
            HOST.hw(1);
            if (!p && pwm[0] === 1'b1) cnt++;
            if (!p && pwm[0] === 1'b1 && cnt == 2) t0 = k;
            if (!p && pwm[0] === 1'b1 && cnt == 3) chk(18'(k - t0), e, "period");
            p = pwm[0];
        end
        chk(18'(cnt), 18'h3, "edges");
    endtask : per
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic t_reset();
        for (int i = 0; i < 9; i++) rr(8'(i), RST_V[i]);
        rr(8'h0B, 8'h00);
        chk(div, 18'h8, "div");
        chk({en, trk, lvl}, 18'h5F, "outs");
        $display("reset done");
    endtask : t_reset
    task automatic t_faults();
        pulse(4'hE);
        rr(8'h00, 8'h35);
        flt = 4'h1;
        rr(8'h00, 8'h37);
        // Over-voltage stays active: the clear must hide it while the mask runs
        ww(8'h00, 8'h80);
        rr(8'h00, 8'h00);
        HOST.hw(1500);
        rr(8'h00, 8'h03);
        flt = 4'h0;
        ww(8'h01, 8'hA5);
        pulse(4'hC);
        rr(8'h00, 8'h00);
        ww(8'h01, 8'hB5);
        $display("faults done");
    endtask : t_faults
    task automatic t_sync();
        sync_run = 1'b1;
        ww(8'h01, 8'h09);
        chk({en, trk}, 18'h3, "track");
        HOST.rd(8'h00, q);
        chk({10'h0, q}, 18'h08, "sync");
        sync_run = 1'b0;
        ww(8'h01, 8'h01);
        chk({en, trk}, 18'h2, "untrack");
        $display("sync done");
    endtask : t_sync
    task automatic t_regs();
        ww(8'h06, 8'h02);
        ww(8'h07, 8'h97);
        ww(8'h08, 8'hFE);
        chk(div, 18'h297FE, "div");
        ww(8'h02, 8'h05);
        HOST.wr(7'h2E, 8'h02, 8'h11, nak);
        chk({nak, lvl}, 18'h25, "level");
        ww(8'h0B, 8'h55);
        rr(8'h0B, 8'h00);
        rr(8'h07, 8'h97);
        $display("regs done");
    endtask : t_regs
    task automatic t_dim();
        ww(8'h01, 8'h06);
        for (int v = 0; v < 2; v++) begin
            pin = 1'(v);
            HOST.hw(8);
            chk({en, 9'h0, pwm}, {10'h0, {8{pin}}}, "direct");
        end
        ww(8'h03, 8'h03);
        ww(8'h04, 8'hFF);
        ww(8'h01, 8'h03);
        HOST.hw(40);
        chk({10'h0, pwm}, 18'hFF, "full");
        ww(8'h03, 8'h02);
        ww(8'h04, 8'h00);
        per(18'd13312);
        ww(8'h01, 8'h23);
        per(18'd6656);
        $display("dimming done");
    endtask : t_dim
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        $display("MISMATCH t=%0t watchdog", $time);
        test_done();
    end
    initial begin
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        HOST.hw(5);
        t_reset();
        t_faults();
        t_sync();
        t_regs();
        t_dim();
        test_done();
    end
endmodule : tb
